// ---- emx_regs.vh ----
// Purpose: constants for the host-side controller of a three-state 8:1 selector
// Assumes: selector outputs are resolved on a shared net outside this design
// Notes:
`ifndef EMX_REGS_VH
`define EMX_REGS_VH
`define EMX_SEL_W 3
`define EMX_SRC_N 8
`define EMX_MAX_DEV 128
`define EMX_GAP_CYC 2
`endif

// ---- emx_ctrl.v ----
// Purpose: host controller driving a bank of three-state 8:1 selectors
// Assumes: one request at a time; enables of all selectors come from here
// Notes: switching enables passes through an all-off gap so low intervals never overlap
`timescale 1ns/1ps
`default_nettype none
`include "emx_regs.vh"
module emx_ctrl #(
   parameter DEV_N = 4,
   parameter DEV_W = 2,
   parameter GAP_CYC = `EMX_GAP_CYC
)(
   input wire clk, // 100 MHz clock
   input wire rst_n, // async reset, active low
   input wire req_valid, // one-cycle request pulse
   input wire [DEV_W-1:0] req_dev, // selector to enable
   input wire [`EMX_SEL_W-1:0] req_sel, // source within selector
   input wire req_off, // request all selectors off
   input wire req_func, // function generator mode
   input wire [`EMX_SRC_N-1:0] func_table, // 16-entry table low half for var d=0
   input wire [`EMX_SRC_N-1:0] func_table_hi, // table half for var d=1
   input wire [DEV_W-1:0] func_dev, // selector whose sources we drive
   output reg req_ready, // idle, may take a request
   output reg [`EMX_SEL_W-1:0] route_select, // select code to all selectors
   output reg [DEV_N-1:0] drive_enable_n, // per-selector enables, active low
   output reg [`EMX_SRC_N-1:0] source_inputs // data for a function-mode selector
);
   localparam ST_IDLE = 2'h0;
   localparam ST_GAP = 2'h1;
   localparam ST_ON = 2'h2;

   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [7:0] gap_reg;
   reg [7:0] gap_next;
   reg [DEV_W-1:0] dev_reg;
   reg [DEV_W-1:0] dev_next;
   reg off_reg;
   reg off_next;
   reg ready_next;
   reg [`EMX_SEL_W-1:0] sel_next;
   reg [DEV_N-1:0] en_next;
   reg [`EMX_SRC_N-1:0] src_next;

   // one enable low, the rest high
   function [DEV_N-1:0] onehot_n;
      input [DEV_W-1:0] d;
      integer k;
      begin
         for (k = 0; k < DEV_N; k = k + 1)
            onehot_n[k] = (d == k[DEV_W-1:0]) ? 1'b0 : 1'b1;
      end
   endfunction

   // gap length, at least one cycle so the all-off phase never vanishes
   function [7:0] gap_load;
      input integer cyc;
      integer c;
      begin
         c = cyc;
         if (c < 1)
            c = 1;
         gap_load = c[7:0];
      end
   endfunction

   // the fourth variable is not a port here, so entries that depend on it read 0
   function [`EMX_SRC_N-1:0] table_sources;
      input [`EMX_SRC_N-1:0] lo;
      input [`EMX_SRC_N-1:0] hi;
      integer k;
      begin
         for (k = 0; k < `EMX_SRC_N; k = k + 1)
            table_sources[k] = (lo[k] == hi[k]) ? lo[k] : 1'b0;
      end
   endfunction

   always @*
   begin
      state_next = state_reg;
      gap_next = gap_reg;
      dev_next = dev_reg;
      off_next = off_reg;
      ready_next = req_ready;
      sel_next = route_select;
      en_next = drive_enable_n;
      src_next = source_inputs;
      case (state_reg)
         ST_IDLE:
         begin
            ready_next = 1'b1;
            if (req_valid && req_ready)
            begin
               ready_next = 1'b0;
               // all enables high first so no two selectors drive together
               en_next = {DEV_N{1'b1}};
               sel_next = req_sel;
               dev_next = req_func ? func_dev : req_dev;
               off_next = req_off;
               if (req_func)
                  src_next = table_sources(func_table, func_table_hi);
               gap_next = gap_load(GAP_CYC);
               state_next = ST_GAP;
            end
         end
         ST_GAP:
         begin
            if (gap_reg <= 8'h01)
               state_next = ST_ON;
            else
               gap_next = gap_reg - 8'h01;
         end
         ST_ON:
         begin
            // only leave the all-off state, never swap one low enable for another
            if (!off_reg && (&drive_enable_n))
               en_next = onehot_n(dev_reg);
            ready_next = 1'b1;
            state_next = ST_IDLE;
         end
         default:
         begin
            en_next = {DEV_N{1'b1}};
            ready_next = 1'b0;
            state_next = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= ST_IDLE;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gap_reg <= 8'h00;
      end
      else
      begin
         gap_reg <= gap_next;
      end
   end

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dev_reg <= {DEV_W{1'b0}};
      end
      else
      begin
         dev_reg <= dev_next;
      end
   end

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         off_reg <= 1'b1;
      end
      else
      begin
         off_reg <= off_next;
      end
   end

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         req_ready <= 1'b0;
      end
      else
      begin
         req_ready <= ready_next;
      end
   end

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         route_select <= {`EMX_SEL_W{1'b0}};
      end
      else
      begin
         route_select <= sel_next;
      end
   end

   // reset floats every selector on the shared net
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         drive_enable_n <= {DEV_N{1'b1}};
      end
      else
      begin
         drive_enable_n <= en_next;
      end
   end

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         source_inputs <= {`EMX_SRC_N{1'b0}};
      end
      else
      begin
         source_inputs <= src_next;
      end
   end
endmodule
`default_nettype wire

// ---- emx_props.sv ----
// Purpose: enable checks
// Assumes: GAP_CYC 2
// Notes: none
`timescale 1ns/1ps
`default_nettype none
module emx_props #(parameter DEV_N = 4)(
   input wire logic clk, // clock
   input wire logic rst_n, // reset
   input wire logic req_valid, // request
   input wire logic req_ready, // idle
   input wire logic [DEV_N-1:0] drive_enable_n // enables
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence all_off; &drive_enable_n; endsequence
   AST_ONE: assert property ($onehot0(~drive_enable_n)) else $error("two on");
   AST_GAP: assert property (!(&drive_enable_n) |-> $stable(drive_enable_n) || $past(&drive_enable_n)) else $error("overlap");
   AST_OFF: assert property (req_valid && req_ready |=> all_off [*3]) else $error("no gap");
   AST_MAX: assert property (DEV_N <= 128) else $error("too many");
   sequence busy_walk; !req_ready [*3] ##1 req_ready; endsequence
   AST_RDY: assert property (req_valid && req_ready |=> busy_walk) else $error("busy span");
   AST_CHG: assert property (!$stable(drive_enable_n) && !(&drive_enable_n) |-> req_ready) else $error("early on");
endmodule
bind emx_ctrl emx_props #(.DEV_N(DEV_N)) emx_props_i(.clk, .rst_n, .req_valid, .req_ready, .drive_enable_n);
`default_nettype wire

// ---- emx_sel_model.sv ----
// Purpose: three-state 8:1 selector model
// Assumes: none
// Notes: outputs float when disabled
`timescale 1ns/1ps
`default_nettype none
module emx_sel_model(
   input wire logic [2:0] route_select, // code
   input wire logic drive_enable_n, // active low
   input wire logic [7:0] source_inputs, // sources
   output wire logic z, // true
   output wire logic z_n // inverse
);
   assign z = drive_enable_n ? 1'bz : source_inputs[route_select];
   assign z_n = drive_enable_n ? 1'bz : ~source_inputs[route_select];
endmodule
`default_nettype wire

// ---- emx_ctrl_bench.sv ----
// Purpose: bench for emx_ctrl
// Assumes: one model on selector 0
// Notes: table halves differ; sources keep only the bits where they agree, the rest read 0
`timescale 1ns/1ps
`default_nettype none
module emx_ctrl_bench;
   localparam logic [7:0] TBL = 8'hA5;
   localparam logic [7:0] TBL_HI = 8'h3C;
   // only bits where both table halves agree keep their value, the rest read 0
   localparam logic [7:0] SRC_EXP = 8'h24;
   logic clk = 0, rst_n = 0, req_valid = 0, req_off = 0, req_func = 0;
   logic [2:0] req_sel = 3'h0;
   logic [1:0] req_dev = 2'h0, func_dev = 2'h0;
   wire z, z_n, rdy;
   wire [2:0] sel;
   wire [7:0] src;
   wire [3:0] en_n;
   int failures = 0, n_checks = 0;
   emx_ctrl emx_ctrl_i(.clk, .rst_n, .req_valid, .req_dev, .req_sel, .req_off,
      .req_func, .func_table(TBL), .func_table_hi(TBL_HI), .func_dev,
      .req_ready(rdy), .route_select(sel), .drive_enable_n(en_n), .source_inputs(src));
   emx_sel_model emx_sel_model_i(.route_select(sel), .drive_enable_n(en_n[0]),
      .source_inputs(src), .z, .z_n);
   task chk(input logic [7:0] s, e);
      n_checks++;
      if (s !== e)
      begin
         failures++;
         $display("BAD %0t mismatch", $time);
      end
   endtask
   task test_done;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task req(input logic [2:0] s, input logic off, input logic fn, input logic [1:0] d);
      @(posedge clk);
      req_sel <= s;
      req_off <= off;
      req_func <= fn;
      req_dev <= d;
      func_dev <= d;
      req_valid <= 1'b1;
      @(posedge clk);
      req_valid <= 1'b0;
      repeat (5) @(posedge clk);
      #1;
   endtask
   task t_route;
      for (int s = 0; s < 8; s++)
      begin
         req(s[2:0], 1'b0, 1'b1, 2'h0);
         chk(en_n, 4'hE);
         chk(sel, s[2:0]);
         chk(src, SRC_EXP);
         chk(rdy, 1'b1);
         chk({z_n, z}, {~SRC_EXP[s], SRC_EXP[s]});
      end
   endtask
   task t_dev;
      req(3'h5, 1'b0, 1'b0, 2'h2);
      chk(en_n, 4'hB);
      chk(sel, 3'h5);
      chk(src, SRC_EXP);
      chk({z_n, z}, 2'bzz);
   endtask
   task t_off;
      req(3'h3, 1'b1, 1'b0, 2'h0);
      chk(en_n, 4'hF);
      chk({z_n, z}, 2'bzz);
   endtask
   task t_reset;
      req(3'h2, 1'b0, 1'b1, 2'h0);
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      #1;
      chk(en_n, 4'hF);
      chk(rdy, 1'b0);
      chk(src, 8'h00);
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      req(3'h1, 1'b0, 1'b0, 2'h1);
      chk(en_n, 4'hD);
   endtask
   initial forever #5 clk = ~clk;
   initial begin #20000; failures++; test_done; end
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      t_route;
      t_dev;
      t_off;
      t_reset;
      test_done;
   end
endmodule
`default_nettype wire
